/* File: uecs_counter.sv */
// event counter: adds a per-cycle occurrence count, cleared by reset or software
`timescale 1ns/1ps

module uecs_counter
  import uecs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [UECS_INC_W-1:0] inc_i,
  output logic [UECS_CNT_W-1:0] cnt_o
);

  logic [UECS_CNT_W-1:0] cnt_ff;
  logic [UECS_CNT_W-1:0] nxt_cnt;

  // software clear wins over a same-cycle increment so a cleared count reads zero
  always_comb begin
    nxt_cnt = cnt_ff;
    if (clr_i) begin
      nxt_cnt = '0;
    end else if (en_i) begin
      nxt_cnt = cnt_ff + {{(UECS_CNT_W-UECS_INC_W){1'b0}}, inc_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign cnt_o = cnt_ff;

endmodule

/* File: uecs_event_select.sv */
// uncore event select: home-logic priority updates, sleep tracking, event selection and counter bus
`timescale 1ns/1ps

// What this block does
// - code 31h mask 07h counts priority updates on any channel.
// - isochronous high or critical request matching issued normal request makes a priority update.
// - the priority update is sent to the memory_request_queue to expedite that request.
// - code 32h masks 01h/02h/04h count dram retries of channel 0/1/2.
// - code 32h mask 07h counts dram retries on any channel.
// - dram retries count only while ras mode is configured.
// - code 33h masks 01h/02h/04h count force-ack conflicts to hub/remote/local.
// - code 33h mask 07h counts all force-ack conflict messages.
// - code 34h mask 01h counts sleeps for hub write-after-read ordering.
// - code 34h mask 02h counts sleeps for remote write-after-read ordering.
// - code 34h mask 04h counts sleeps for local write-after-read ordering.
// - code 34h mask 08h counts sleeps for hub address clashes.
// - code 34h mask 10h counts sleeps for remote address clashes.
// - code 34h mask 20h counts sleeps for local address clashes.
// - a sleeping request is not eligible for scheduling to the queue.
// - code 31h masks 01h/02h/04h count priority updates on channel 0/1/2.
module uecs_event_select
  import uecs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // isochronous_class request arriving at the home_agent_logic
  input wire logic isochronous_class_req_vld_i,
  input wire logic [1:0] isochronous_class_req_prio_i,
  input wire logic [1:0] isochronous_class_req_chan_i,
  input wire logic isochronous_class_match_issued_i,
  output logic prio_upd_o,
  output logic [UECS_NUM_CHAN-1:0] prio_upd_chan_o,
  // integrated_dram_controller retries, one strobe per channel
  input wire logic [UECS_NUM_CHAN-1:0] dram_retry_i,
  output logic ras_mode_o,
  // force-ack conflict messages: bit 0 hub, 1 remote, 2 local
  input wire logic [UECS_NUM_CHAN-1:0] force_ack_conflict_i,
  // sleep tracking of home_agent_logic requests
  input wire logic sleep_set_i,
  input wire logic [UECS_REQ_ID_W-1:0] sleep_id_i,
  input wire logic [UECS_NUM_SUB-1:0] sleep_cause_i,
  input wire logic wake_i,
  input wire logic [UECS_REQ_ID_W-1:0] wake_id_i,
  output logic [UECS_NUM_REQ-1:0] sched_eligible_o
);

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  uecs_wb_state_t wb_state_ff;
  uecs_wb_state_t nxt_wb_state;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] code_ff;
  logic [7:0] nxt_code;
  logic [7:0] umask_ff;
  logic [7:0] nxt_umask;
  logic en_ff;
  logic nxt_en;
  logic ras_ff;
  logic nxt_ras;
  logic wr_commit;
  logic cnt_clr;
  logic [31:0] byte_mask;
  logic [31:0] sel_word;
  logic [31:0] mode_word;
  logic [UECS_CNT_W-1:0] cnt;
  logic [UECS_NUM_REQ-1:0] sleep_ff;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // ack is registered, so a write lands on the edge where the master sees ack high
  assign wr_commit = (wb_state_ff == UECS_WB_ACK) && wb_cyc_i && wb_stb_i && wb_we_i;
  assign cnt_clr = wr_commit && (wb_adr_i == UECS_ADR_CNT_LO);
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign sel_word = {15'h0000, en_ff, umask_ff, code_ff};
  assign mode_word = {31'h00000000, ras_ff};

  always_comb begin
    logic [31:0] wsel;
    logic [31:0] wmode;
    wsel = (sel_word & ~byte_mask) | (wb_dat_i & byte_mask);
    wmode = (mode_word & ~byte_mask) | (wb_dat_i & byte_mask);
    nxt_wb_state = wb_state_ff;
    nxt_rdata = rdata_ff;
    nxt_code = code_ff;
    nxt_umask = umask_ff;
    nxt_en = en_ff;
    nxt_ras = ras_ff;
    case (wb_state_ff)
      UECS_WB_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          nxt_wb_state = UECS_WB_ACK;
          case (wb_adr_i)
            UECS_ADR_SELECT: nxt_rdata = sel_word;
            UECS_ADR_MODE: nxt_rdata = mode_word;
            UECS_ADR_CNT_LO: nxt_rdata = cnt[31:0];
            UECS_ADR_CNT_HI: nxt_rdata = {16'h0000, cnt[UECS_CNT_W-1:32]};
            UECS_ADR_SLEEP: nxt_rdata = {24'h000000, sleep_ff};
            default: nxt_rdata = 32'h00000000;
          endcase
        end
      end
      UECS_WB_ACK: begin
        nxt_wb_state = UECS_WB_IDLE;
        if (wr_commit && wb_adr_i == UECS_ADR_SELECT) begin
          nxt_code = wsel[UECS_SEL_CODE_LSB +: 8];
          nxt_umask = wsel[UECS_SEL_MASK_LSB +: 8];
          nxt_en = wsel[UECS_SEL_EN_BIT];
        end
        if (wr_commit && wb_adr_i == UECS_ADR_MODE) begin
          nxt_ras = wmode[UECS_MODE_RAS_BIT];
        end
      end
      default: begin
        nxt_wb_state = UECS_WB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_state_ff <= UECS_WB_IDLE;
      rdata_ff <= 32'h00000000;
      code_ff <= UECS_RST_CODE;
      umask_ff <= UECS_RST_MASK;
      en_ff <= UECS_RST_EN;
      ras_ff <= UECS_RST_RAS;
    end else begin
      wb_state_ff <= nxt_wb_state;
      rdata_ff <= nxt_rdata;
      code_ff <= nxt_code;
      umask_ff <= nxt_umask;
      en_ff <= nxt_en;
      ras_ff <= nxt_ras;
    end
  end

  assign wb_ack_o = (wb_state_ff == UECS_WB_ACK);
  assign wb_dat_o = rdata_ff;
  assign ras_mode_o = ras_ff;

  // ----------------------------------------------------------------
  // priority update generation
  // ----------------------------------------------------------------
  logic prio_upd_ff;
  logic nxt_prio_upd;
  logic [UECS_NUM_CHAN-1:0] prio_chan_ff;
  logic [UECS_NUM_CHAN-1:0] nxt_prio_chan;

  always_comb begin
    logic urgent;
    urgent = (isochronous_class_req_prio_i == UECS_PRIO_HIGH) || (isochronous_class_req_prio_i == UECS_PRIO_CRIT);
    // only an already issued normal-priority match needs expediting
    nxt_prio_upd = isochronous_class_req_vld_i && urgent && isochronous_class_match_issued_i;
    nxt_prio_chan = '0;
    if (nxt_prio_upd && isochronous_class_req_chan_i < 2'(UECS_NUM_CHAN)) begin
      nxt_prio_chan[isochronous_class_req_chan_i] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_upd_ff <= 1'b0;
      prio_chan_ff <= '0;
    end else begin
      prio_upd_ff <= nxt_prio_upd;
      prio_chan_ff <= nxt_prio_chan;
    end
  end

  assign prio_upd_o = prio_upd_ff;
  assign prio_upd_chan_o = prio_chan_ff;

  // ----------------------------------------------------------------
  // sleep table
  // ----------------------------------------------------------------
  // a request that is put to sleep and woken in one cycle stays asleep: the sleep wins
  genvar gi;
  generate
    for (gi = 0; gi < UECS_NUM_REQ; gi = gi + 1) begin : g_req
      logic nxt_sleep;
      always_comb begin
        nxt_sleep = sleep_ff[gi];
        if (wake_i && wake_id_i == UECS_REQ_ID_W'(gi)) begin
          nxt_sleep = 1'b0;
        end
        if (sleep_set_i && sleep_id_i == UECS_REQ_ID_W'(gi)) begin
          nxt_sleep = 1'b1;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sleep_ff[gi] <= 1'b0;
        end else begin
          sleep_ff[gi] <= nxt_sleep;
        end
      end
      assign sched_eligible_o[gi] = ~sleep_ff[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------
  logic [UECS_NUM_SUB-1:0] sub_hit;
  logic [UECS_INC_W-1:0] inc;

  always_comb begin
    logic [UECS_NUM_SUB-1:0] raw;
    raw = '0;
    case (code_ff)
      UECS_EV_PRIO_UPDATE: raw = {3'b000, prio_chan_ff};
      UECS_EV_DRAM_RETRY: raw = {3'b000, dram_retry_i & {UECS_NUM_CHAN{ras_ff}}};
      UECS_EV_FORCE_ACK: raw = {3'b000, force_ack_conflict_i};
      // bits 0..2 ordering (hub, remote, local), bits 3..5 address clash
      UECS_EV_SLEEP: raw = sleep_cause_i & {UECS_NUM_SUB{sleep_set_i}};
      default: raw = '0;
    endcase
    // each of mask bits 0..5 selects one sub-event (bits 6 and 7 select none), and every selected hit adds one to the count
    sub_hit = raw & umask_ff[UECS_NUM_SUB-1:0];
    inc = '0;
    for (int i = 0; i < UECS_NUM_SUB; i++) begin
      inc = inc + UECS_INC_W'(sub_hit[i]);
    end
  end

  uecs_counter u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(cnt_clr),
    .en_i(en_ff),
    .inc_i(inc),
    .cnt_o(cnt)
  );

endmodule

/* File: uecs_event_select_bench.sv */
// testbench: table-driven event counting, then bus, sleep and reset corner cases
`timescale 1ns/1ps
module uecs_event_select_bench;
  import uecs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, prio_upd_o, ras_mode_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic isochronous_class_req_vld_i = 1'b0, isochronous_class_match_issued_i = 1'b0, sleep_set_i = 1'b0, wake_i = 1'b0;
  logic [1:0] isochronous_class_req_prio_i = 2'h0, isochronous_class_req_chan_i = 2'h0;
  logic [2:0] prio_upd_chan_o, dram_retry_i = 3'h0, force_ack_conflict_i = 3'h0;
  logic [2:0] sleep_id_i = 3'h0, wake_id_i = 3'h0;
  logic [5:0] sleep_cause_i = 6'h0;
  logic [7:0] sched_eligible_o, slp = 8'h00;
  logic [3:0] lanes = 4'hf;
  int miscompares = 0, n_tests = 0;
  // ----------------------------------------------------------------
  // rows: code, mask, ras, kind (0 retry 1 force-ack 2 sleep 3 isochronous_class), stimulus, count
  // ----------------------------------------------------------------
  // the last row asks for channel 3: an update pulse with no channel bit, so nothing counts
  logic [35:0] rows [23] = '{36'h32_07_1_0_03_2, 36'h32_01_1_0_07_1, 36'h32_02_1_0_02_1,
    36'h32_04_1_0_03_0, 36'h32_07_0_0_07_0, 36'h33_01_0_1_01_1, 36'h33_02_0_1_06_1,
    36'h33_04_0_1_04_1, 36'h33_07_0_1_07_3, 36'h34_01_0_2_01_1, 36'h34_02_0_2_02_1,
    36'h34_04_0_2_04_1, 36'h34_08_0_2_08_1, 36'h34_10_0_2_10_1, 36'h34_20_0_2_20_1,
    36'h34_1e_0_2_01_0, 36'h31_07_0_3_82_1, 36'h31_01_0_3_00_1, 36'h31_02_0_3_00_0,
    36'h31_07_0_3_41_0, 36'h31_07_0_3_21_0, 36'h30_07_1_0_07_0, 36'h31_07_0_3_03_0};
  uecs_event_select u_dut (.*);
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= lanes;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // v[7] critical, v[6] normal priority, v[5] no issued match
  task automatic fire(input logic [3:0] k, input logic [7:0] v, input logic [2:0] id);
    @(posedge clk_i);
    dram_retry_i <= (k == 4'h0) ? v[2:0] : 3'h0;
    force_ack_conflict_i <= (k == 4'h1) ? v[2:0] : 3'h0;
    sleep_set_i <= (k == 4'h2);
    sleep_cause_i <= v[5:0];
    sleep_id_i <= id;
    isochronous_class_req_vld_i <= (k == 4'h3);
    isochronous_class_match_issued_i <= !v[5];
    isochronous_class_req_prio_i <= v[6] ? UECS_PRIO_NORMAL : (v[7] ? UECS_PRIO_CRIT : UECS_PRIO_HIGH);
    isochronous_class_req_chan_i <= v[1:0];
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("reset_out", 48'h00ff, {2'h0, wb_dat_o, wb_ack_o, prio_upd_o, ras_mode_o, prio_upd_chan_o, sched_eligible_o});
    foreach (rows[i]) begin
      wb(1'b1, UECS_ADR_CNT_LO, 32'h0);
      wb(1'b1, UECS_ADR_MODE, {31'h0, rows[i][16]});
      wb(1'b1, UECS_ADR_SELECT, {15'h0, 1'b1, rows[i][27:20], rows[i][35:28]});
      chk("ras_mode", {47'h0, rows[i][16]}, {47'h0, ras_mode_o});
      fire(rows[i][15:12], rows[i][11:4], i[2:0]);
      fire(4'hf, 8'h00, 3'h0);
      if (rows[i][15:12] == 4'h2) slp[i[2:0]] = 1'b1;
      repeat (2) @(posedge clk_i);
      wb(1'b0, UECS_ADR_CNT_LO, 32'h0);
      chk("count", {44'h0, rows[i][3:0]}, {16'h0, rd});
    end
    // ----------------------------------------------------------------
    // back-to-back events, read-only and unmapped places
    // ----------------------------------------------------------------
    wb(1'b1, UECS_ADR_CNT_LO, 32'h0);
    wb(1'b1, UECS_ADR_MODE, 32'h1);
    wb(1'b1, UECS_ADR_SELECT, 32'h1_07_32);
    repeat (3) fire(4'h0, 8'h07, 3'h0);
    fire(4'hf, 8'h00, 3'h0);
    wb(1'b1, UECS_ADR_CNT_HI, 32'hffff);
    wb(1'b0, UECS_ADR_CNT_LO, 32'h0);
    chk("burst_count", 48'h9, {16'h0, rd});
    wb(1'b0, UECS_ADR_CNT_HI, 32'h0);
    chk("count_hi", 48'h0, {16'h0, rd});
    wb(1'b1, 8'h20, 32'hffff_ffff);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 48'h0, {16'h0, rd});
    // only the lowest byte lane is enabled, so mask and enable keep their values
    lanes = 4'h1;
    wb(1'b1, UECS_ADR_SELECT, 32'hffff_ff33);
    lanes = 4'hf;
    wb(1'b0, UECS_ADR_SELECT, 32'h0);
    chk("byte_lanes", 48'h1_07_33, {16'h0, rd});
    // ----------------------------------------------------------------
    // sleeping requests, then wake every id
    // ----------------------------------------------------------------
    chk("eligible", {40'h0, ~slp}, {40'h0, sched_eligible_o});
    wb(1'b0, UECS_ADR_SLEEP, 32'h0);
    chk("sleep_flags", {40'h0, slp}, {16'h0, rd});
    for (int j = 0; j < 8; j++) begin
      @(posedge clk_i);
      wake_i <= 1'b1;
      wake_id_i <= j[2:0];
    end
    @(posedge clk_i);
    wake_i <= 1'b0;
    @(posedge clk_i);
    chk("woken", 48'hff, {40'h0, sched_eligible_o});
    // a second reset in mid-run clears the count and the selection
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("reset_again", 48'h00ff, {2'h0, wb_dat_o, wb_ack_o, prio_upd_o, ras_mode_o, prio_upd_chan_o, sched_eligible_o});
    wb(1'b0, UECS_ADR_CNT_LO, 32'h0);
    chk("count_reset", 48'h0, {16'h0, rd});
    wb(1'b0, UECS_ADR_SELECT, 32'h0);
    chk("select_reset", 48'h0, {16'h0, rd});
    results();
  end
endmodule
bind uecs_event_select uecs_event_select_sva u_sva (.*);

/* File: uecs_event_select_sva.sv */
// checker: port timing of bus answers, priority updates and sleep eligibility
`timescale 1ns/1ps
module uecs_event_select_sva
  import uecs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic isochronous_class_req_vld_i,
  input wire logic [1:0] isochronous_class_req_prio_i,
  input wire logic [1:0] isochronous_class_req_chan_i,
  input wire logic isochronous_class_match_issued_i,
  input wire logic prio_upd_o,
  input wire logic [UECS_NUM_CHAN-1:0] prio_upd_chan_o,
  input wire logic sleep_set_i,
  input wire logic [UECS_REQ_ID_W-1:0] sleep_id_i,
  input wire logic wake_i,
  input wire logic [UECS_REQ_ID_W-1:0] wake_id_i,
  input wire logic [UECS_NUM_REQ-1:0] sched_eligible_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic upd_q;
  assign upd_q = isochronous_class_req_vld_i && isochronous_class_match_issued_i &&
    (isochronous_class_req_prio_i == UECS_PRIO_HIGH || isochronous_class_req_prio_i == UECS_PRIO_CRIT);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not answered next cycle");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_upd_made: assert property (upd_q |=> prio_upd_o)
    else $error("priority update missing");
  chk_upd_none: assert property (!upd_q |=> !prio_upd_o)
    else $error("priority update without cause");
  chk_upd_chan: assert property (upd_q && isochronous_class_req_chan_i != 2'h3 |=> prio_upd_chan_o == (3'h1 << $past(isochronous_class_req_chan_i)))
    else $error("priority update on wrong channel");
  chk_chan_quiet: assert property (!prio_upd_o |-> prio_upd_chan_o == 3'h0)
    else $error("channel bits without update");
  chk_sleep_block: assert property (sleep_set_i |=> !sched_eligible_o[$past(sleep_id_i)])
    else $error("sleeping request still eligible");
  chk_wake_free: assert property (wake_i && !(sleep_set_i && sleep_id_i == wake_id_i) |=> sched_eligible_o[$past(wake_id_i)])
    else $error("woken request not eligible");
  chk_elig_hold: assert property (!sleep_set_i && !wake_i |=> $stable(sched_eligible_o))
    else $error("eligibility changed without cause");
  cover property (upd_q ##1 prio_upd_o);
  cover property (sleep_set_i);
  cover property (wake_i);
endmodule

/* File: uecs_pkg.sv */
// package: register map, field positions, event codes and widths of the event count select block
package uecs_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the wishbone bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] UECS_ADR_SELECT = 8'h00;
  localparam logic [7:0] UECS_ADR_MODE = 8'h04;
  localparam logic [7:0] UECS_ADR_CNT_LO = 8'h08;
  localparam logic [7:0] UECS_ADR_CNT_HI = 8'h0c;
  localparam logic [7:0] UECS_ADR_SLEEP = 8'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int UECS_SEL_CODE_LSB = 0;
  localparam int UECS_SEL_MASK_LSB = 8;
  localparam int UECS_SEL_EN_BIT = 16;
  localparam int UECS_MODE_RAS_BIT = 0;
  localparam logic [7:0] UECS_RST_CODE = 8'h00;
  localparam logic [7:0] UECS_RST_MASK = 8'h00;
  localparam logic UECS_RST_EN = 1'b0;
  localparam logic UECS_RST_RAS = 1'b0;

  // ----------------------------------------------------------------
  // event codes and unit-mask layout
  // ----------------------------------------------------------------
  localparam logic [7:0] UECS_EV_PRIO_UPDATE = 8'h31;
  localparam logic [7:0] UECS_EV_DRAM_RETRY = 8'h32;
  localparam logic [7:0] UECS_EV_FORCE_ACK = 8'h33;
  localparam logic [7:0] UECS_EV_SLEEP = 8'h34;
  localparam int UECS_NUM_SUB = 6;
  localparam int UECS_NUM_CHAN = 3;

  // isochronous_class priority encoding of an incoming request
  localparam logic [1:0] UECS_PRIO_NORMAL = 2'h0;
  localparam logic [1:0] UECS_PRIO_HIGH = 2'h1;
  localparam logic [1:0] UECS_PRIO_CRIT = 2'h2;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int UECS_CNT_W = 48;
  localparam int UECS_CNT_HI_W = 16;
  localparam int UECS_INC_W = 3;
  localparam int UECS_NUM_REQ = 8;
  localparam int UECS_REQ_ID_W = 3;

  typedef enum logic [1:0] {
    UECS_WB_IDLE = 2'b01,
    UECS_WB_ACK = 2'b10
  } uecs_wb_state_t;

endpackage
